// ===== hdl/modbus_slave_pkg.sv
// Purpose: Shared constants and types for the serial slave responder
// Assumes: 16-bit holding registers, one query per frame
// Notes: Register indices are internal slot numbers, not bus addresses
package modbus_slave_pkg;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_READ_FILE = 8'h14;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_FAIL = 8'h04;
  localparam logic [7:0] EXC_BUSY = 8'h06;
  localparam logic [7:0] EXC_NAK = 8'h07;
  localparam logic [7:0] EXC_OVERFLOW = 8'h09;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [3:0] QUERY_LEN = 4'h8;
  localparam logic [7:0] EXC_LEN = 8'h05;
  localparam logic [7:0] ECHO_LEN = 8'h08;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] HYST_MAX_HI = 16'h42C8;
  localparam logic [15:0] HYST_MAX_LO = 16'h0000;
  localparam logic [15:0] STATUS_MAX = 16'h00FF;
  localparam logic [15:0] MAX_BOOL = 16'h0001;
  localparam logic [15:0] MAX_TRI = 16'h0002;
  localparam logic [15:0] MAX_BLOCK = 16'h0003;
  localparam logic [15:0] MAX_LANG = 16'h0005;
  localparam logic [15:0] MAX_TYPE = 16'h0012;
  localparam logic [15:0] OFS_HYST_HI = 16'h0029;
  localparam logic [15:0] OFS_HYST_LO = 16'h002A;
  localparam logic [15:0] OFS_TEMP = 16'h0081;
  localparam logic [15:0] OFS_A1S1_EV = 16'h008D;
  localparam logic [15:0] OFS_A1S2_TYPE = 16'h008E;
  localparam logic [15:0] OFS_A1S2_EV = 16'h008F;
  localparam logic [15:0] OFS_A2S1_TYPE = 16'h0090;
  localparam logic [15:0] OFS_A2S1_EV = 16'h0091;
  localparam logic [15:0] OFS_A2S2_TYPE = 16'h0092;
  localparam logic [15:0] OFS_A2S2_EV = 16'h0093;
  localparam logic [15:0] OFS_DIAG = 16'h009A;
  localparam logic [15:0] OFS_DECIMAL = 16'h009B;
  localparam logic [15:0] OFS_TC_DIAG = 16'h009F;
  localparam logic [15:0] OFS_MAINS = 16'h00A6;
  localparam logic [15:0] OFS_LOWER_EN = 16'h00AE;
  localparam logic [15:0] OFS_LOWER_SEL = 16'h00AF;
  localparam logic [15:0] OFS_LANG = 16'h00C0;
  localparam logic [15:0] OFS_LATCH = 16'h00C8;
  localparam logic [15:0] OFS_STATUS = 16'h00C9;
  localparam logic [15:0] OFS_BLOCK = 16'h00CA;
  typedef enum logic [4:0] {
    IX_HYST_HI, IX_HYST_LO, IX_TEMP, IX_A1S1_EV, IX_A1S2_TYPE, IX_A1S2_EV,
    IX_A2S1_TYPE, IX_A2S1_EV, IX_A2S2_TYPE, IX_A2S2_EV, IX_DIAG, IX_DECIMAL,
    IX_TC_DIAG, IX_MAINS, IX_LOWER_EN, IX_LOWER_SEL, IX_LANG, IX_LATCH,
    IX_STATUS, IX_BLOCK, IX_COUNT
  } reg_idx_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic err;
    logic frame_end;
  } rx_t;
  typedef struct packed {
    logic [15:0] hyst_hi;
    logic [3:0] event_high;
    logic alarm_latch;
    logic [1:0] block_sel;
    logic [1:0] diag_route;
    logic mains_50hz;
    logic lower_disp_off;
    logic tc_diag_off;
  } cfg_t;
endpackage : modbus_slave_pkg

// ===== hdl/frame_crc16.sv
// Purpose: Running CRC-16 over a byte stream, reflected form
// Assumes: One byte per enable pulse
// Notes: Clear has priority over enable
`timescale 1ns/1ps
`default_nettype none
module frame_crc16 (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Byte stream
  input wire logic i_clear,
  input wire logic i_en,
  input wire logic [7:0] i_data,
  // Running remainder
  output logic [15:0] o_crc
);
  import modbus_slave_pkg::*;
  logic [15:0] crc_next;

  always_comb
  begin
    crc_next = o_crc ^ {8'h00, i_data};
    for (int b = 0; b < 8; b++)
    begin
      crc_next = crc_next[0] ? ((crc_next >> 1) ^ CRC_POLY) : (crc_next >> 1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_crc <= CRC_INIT;
    else if (i_clear)
      o_crc <= CRC_INIT;
    else if (i_en)
      o_crc <= crc_next;
  end
endmodule : frame_crc16
`default_nettype wire

// ===== hdl/param_regfile.sv
// Purpose: Alarm and display set-up registers with range checking
// Assumes: Writes are issued only after the range check passed
// Notes: The alarm status word is live state; writes to it change nothing
`timescale 1ns/1ps
`default_nettype none
module param_regfile (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Read port
  input wire logic [15:0] i_rd_addr,
  output logic [15:0] o_rd_data,
  output logic o_rd_hit,
  // Write port
  input wire logic [15:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr_en,
  output logic o_wr_hit,
  output logic o_wr_ok,
  // Alarm state and configuration
  input wire logic [3:0] i_alarm_active,
  output modbus_slave_pkg::cfg_t o_cfg
);
  import modbus_slave_pkg::*;
  localparam int NUM_REGS = int'(IX_COUNT);
  logic [15:0] regs_reg [NUM_REGS];
  logic [5:0] rd_look;
  logic [5:0] wr_look;
  logic [3:0] event_high;

  function automatic logic [5:0] lookup(input logic [15:0] a);
    case (a)
      OFS_HYST_HI: lookup = {1'b1, IX_HYST_HI};
      OFS_HYST_LO: lookup = {1'b1, IX_HYST_LO};
      OFS_TEMP: lookup = {1'b1, IX_TEMP};
      OFS_A1S1_EV: lookup = {1'b1, IX_A1S1_EV};
      OFS_A1S2_TYPE: lookup = {1'b1, IX_A1S2_TYPE};
      OFS_A1S2_EV: lookup = {1'b1, IX_A1S2_EV};
      OFS_A2S1_TYPE: lookup = {1'b1, IX_A2S1_TYPE};
      OFS_A2S1_EV: lookup = {1'b1, IX_A2S1_EV};
      OFS_A2S2_TYPE: lookup = {1'b1, IX_A2S2_TYPE};
      OFS_A2S2_EV: lookup = {1'b1, IX_A2S2_EV};
      OFS_DIAG: lookup = {1'b1, IX_DIAG};
      OFS_DECIMAL: lookup = {1'b1, IX_DECIMAL};
      OFS_TC_DIAG: lookup = {1'b1, IX_TC_DIAG};
      OFS_MAINS: lookup = {1'b1, IX_MAINS};
      OFS_LOWER_EN: lookup = {1'b1, IX_LOWER_EN};
      OFS_LOWER_SEL: lookup = {1'b1, IX_LOWER_SEL};
      OFS_LANG: lookup = {1'b1, IX_LANG};
      OFS_LATCH: lookup = {1'b1, IX_LATCH};
      OFS_STATUS: lookup = {1'b1, IX_STATUS};
      OFS_BLOCK: lookup = {1'b1, IX_BLOCK};
      default: lookup = 6'h00;
    endcase
  endfunction : lookup

  // Hysteresis high word bound admits floats from +0.0 up to 100.0
  function automatic logic [15:0] max_of(input logic [4:0] ix);
    case (ix)
      IX_HYST_HI: max_of = HYST_MAX_HI;
      IX_HYST_LO: max_of = HYST_MAX_LO;
      IX_A1S2_TYPE, IX_A2S1_TYPE, IX_A2S2_TYPE: max_of = MAX_TYPE;
      IX_TEMP, IX_DIAG, IX_DECIMAL, IX_LOWER_SEL: max_of = MAX_TRI;
      IX_LANG: max_of = MAX_LANG;
      IX_BLOCK: max_of = MAX_BLOCK;
      IX_STATUS: max_of = STATUS_MAX;
      default: max_of = MAX_BOOL;
    endcase
  endfunction : max_of

  assign rd_look = lookup(i_rd_addr);
  assign wr_look = lookup(i_wr_addr);
  assign o_rd_hit = rd_look[5];
  assign o_wr_hit = wr_look[5];
  assign o_wr_ok = i_wr_data <= max_of(wr_look[4:0]);
  // Event direction per setpoint, 0 low and 1 high
  assign event_high = {regs_reg[IX_A2S2_EV][0], regs_reg[IX_A2S1_EV][0],
                       regs_reg[IX_A1S2_EV][0], regs_reg[IX_A1S1_EV][0]};
  assign o_rd_data = (rd_look[4:0] == IX_STATUS) ?
                     {8'h00, event_high, i_alarm_active} :
                     regs_reg[rd_look[4:0]];

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_reg[i] <= REG_RESET;
    end
    else if (i_wr_en && o_wr_hit && o_wr_ok && (wr_look[4:0] != IX_STATUS))
      regs_reg[wr_look[4:0]] <= i_wr_data;
  end

  assign o_cfg.hyst_hi = regs_reg[IX_HYST_HI];
  assign o_cfg.event_high = event_high;
  assign o_cfg.alarm_latch = regs_reg[IX_LATCH][0];
  assign o_cfg.block_sel = regs_reg[IX_BLOCK][1:0];
  assign o_cfg.diag_route = regs_reg[IX_DIAG][1:0];
  assign o_cfg.mains_50hz = regs_reg[IX_MAINS][0];
  assign o_cfg.lower_disp_off = regs_reg[IX_LOWER_EN][0];
  assign o_cfg.tc_diag_off = regs_reg[IX_TC_DIAG][0];

  a_status_pack: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rd_look[4:0] == IX_STATUS && o_rd_hit) |->
    o_rd_data == {8'h00, regs_reg[IX_A2S2_EV][0], regs_reg[IX_A2S1_EV][0],
                  regs_reg[IX_A1S2_EV][0], regs_reg[IX_A1S1_EV][0], i_alarm_active})
    else $error("alarm status word packed wrongly");
  a_range_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_wr_hit && !o_wr_ok) |=> $stable(o_cfg))
    else $error("out of range value was stored");
  a_freq_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr_en && i_wr_addr == OFS_MAINS && i_wr_data <= MAX_BOOL) |=>
    o_cfg.mains_50hz == $past(i_wr_data[0]))
    else $error("mains frequency select not taken");
endmodule : param_regfile
`default_nettype wire

// ===== hdl/modbus_slave_exception_regs.sv
// Purpose: Serial slave query responder with exception answers and set-up registers
// Assumes: Receiver gives bytes, a parity error flag and a frame-end pulse after the
//          last byte; transmitter takes bytes by valid and ready; all on i_clk
// Notes: Supported functions are read holding, read input, write single, file read
//
// Notes on behaviour
// - Clean serviceable query gets a normal reply echoing the function code.
// - Refused query is answered with function code plus 80 hex.
// - Frames with parity or CRC error are discarded without any reply.
// - Exception reply carries one exception code in place of data.
// - Unimplemented register address is answered with exception 02.
// - Unsupported function is answered with exception 01.
// - Write value outside the register's range is refused with exception 03.
// - Internal fault state makes a valid query end with exception 04.
// - Busy device rejects queries with a busy code; master retries later.
// - Device unable to process the message answers exception 07.
// - File read asking more than the reply buffer holds gets exception 09.
// - Alarm status bits 0 to 3 show setpoint alarm active state.
// - Alarm status bits 4 to 7 show event direction, 1 high.
// - Setpoint event registers pick low alarm at 0, high at 1.
// - Output 1 latching register: 0 non-latching, 1 latching.
// - Blocking register: 0 off, 1 setpoint 1, 2 setpoint 2, 3 both.
// - Hysteresis accepts only 0.0 to 100 percent; other values refused.
// - Mains frequency register: 0 selects 60 Hz, 1 selects 50 Hz.
`timescale 1ns/1ps
`default_nettype none
module modbus_slave_exception_regs #(
  parameter logic [15:0] RESP_WORDS = 16'h0008
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Received bytes
  input wire modbus_slave_pkg::rx_t i_rx,
  // Bytes to transmit
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  // Device state
  input wire logic [7:0] i_slave_addr,
  input wire logic i_busy,
  input wire logic i_fault,
  input wire logic i_nak,
  input wire logic [3:0] i_alarm_active,
  // Configuration
  output modbus_slave_pkg::cfg_t o_cfg
);
  import modbus_slave_pkg::*;

  typedef enum logic [2:0] {ST_RX, ST_EVAL, ST_CHECK, ST_LOAD, ST_SEND} state_t;
  typedef enum logic [1:0] {RESP_EXC, RESP_READ, RESP_WRITE} resp_t;

  state_t state_reg;
  resp_t kind_reg;
  logic [7:0] buf_reg [QUERY_LEN];
  logic [3:0] rx_cnt_reg;
  logic rx_bad_reg;
  logic [7:0] exc_reg;
  logic [7:0] tx_idx_reg;
  logic [7:0] tx_len_reg;
  logic [7:0] tx_data_reg;
  logic [15:0] chk_reg;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [7:0] fc;
  logic [15:0] start;
  logic [15:0] arg;
  logic end_ev;
  logic frame_good;
  logic fc_known;
  logic fc_read;
  logic pre_ok;
  logic [7:0] eval_exc;
  logic wr_en;
  logic wr_hit;
  logic wr_ok;
  logic rd_hit;
  logic [15:0] rd_data;
  logic [15:0] rd_addr;
  logic [7:0] doff;
  logic [7:0] byte_next;
  logic tx_fire;

  assign fc = buf_reg[1];
  assign start = {buf_reg[2], buf_reg[3]};
  assign arg = {buf_reg[4], buf_reg[5]};
  assign end_ev = (state_reg == ST_RX) && i_rx.frame_end;
  // Remainder over a whole frame including its CRC is zero when intact
  assign frame_good = (rx_cnt_reg >= 4'h4) && !rx_bad_reg && (rx_crc == 16'h0000) &&
                      (buf_reg[0] == i_slave_addr);
  assign fc_read = (fc == FC_READ_HOLD) || (fc == FC_READ_INPUT) || (fc == FC_READ_FILE);
  assign fc_known = fc_read || (fc == FC_WRITE_ONE);
  assign pre_ok = !i_busy && !i_fault && !i_nak && fc_known && (rx_cnt_reg == QUERY_LEN);
  assign tx_fire = o_tx_valid && i_tx_ready;
  assign o_tx_valid = state_reg == ST_SEND;
  assign o_tx_data = tx_data_reg;
  assign wr_en = (state_reg == ST_EVAL) && (eval_exc == EXC_NONE) && (fc == FC_WRITE_ONE);
  assign doff = tx_idx_reg - 8'h03;
  assign rd_addr = (state_reg == ST_CHECK) ? (start + chk_reg) :
                   (start + {9'h000, doff[7:1]});

  // Query reception; bytes arriving while a reply is in progress are dropped
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_cnt_reg <= 4'h0;
      rx_bad_reg <= 1'b0;
      for (int i = 0; i < int'(QUERY_LEN); i++)
        buf_reg[i] <= 8'h00;
    end
    else if ((end_ev && !frame_good) || (state_reg == ST_SEND))
    begin
      rx_cnt_reg <= 4'h0;
      rx_bad_reg <= 1'b0;
    end
    else if ((state_reg == ST_RX) && i_rx.valid)
    begin
      if (rx_cnt_reg < QUERY_LEN)
      begin
        buf_reg[rx_cnt_reg[2:0]] <= i_rx.data;
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
      rx_bad_reg <= rx_bad_reg || i_rx.err || (rx_cnt_reg == QUERY_LEN);
    end
  end

  frame_crc16 u_rx_crc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(end_ev || (state_reg != ST_RX)),
    .i_en((state_reg == ST_RX) && i_rx.valid),
    .i_data(i_rx.data),
    .o_crc(rx_crc)
  );

  frame_crc16 u_tx_crc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(state_reg == ST_EVAL),
    .i_en(tx_fire && (tx_idx_reg < tx_len_reg - 8'h02)),
    .i_data(tx_data_reg),
    .o_crc(tx_crc)
  );

  param_regfile u_regs (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_rd_addr(rd_addr),
    .o_rd_data(rd_data),
    .o_rd_hit(rd_hit),
    .i_wr_addr(start),
    .i_wr_data(arg),
    .i_wr_en(wr_en),
    .o_wr_hit(wr_hit),
    .o_wr_ok(wr_ok),
    .i_alarm_active(i_alarm_active),
    .o_cfg(o_cfg)
  );

  // Exception choice in priority order
  always_comb
  begin
    if (i_busy)
      eval_exc = EXC_BUSY;
    else if (i_fault)
      eval_exc = EXC_FAIL;
    else if (i_nak)
      eval_exc = EXC_NAK;
    else if (!fc_known)
      eval_exc = EXC_ILL_FUNC;
    else if (rx_cnt_reg != QUERY_LEN)
      eval_exc = EXC_VALUE;
    else if ((fc == FC_READ_FILE) && (arg > RESP_WORDS))
      eval_exc = EXC_OVERFLOW;
    else if (fc_read && ((arg == 16'h0000) || (arg > RESP_WORDS)))
      eval_exc = EXC_VALUE;
    else if ((fc == FC_WRITE_ONE) && !wr_hit)
      eval_exc = EXC_ADDR;
    else if ((fc == FC_WRITE_ONE) && !wr_ok)
      eval_exc = EXC_VALUE;
    else
      eval_exc = EXC_NONE;
  end

  // Sequencing of evaluation, read address walk and reply
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ST_RX;
      kind_reg <= RESP_EXC;
      exc_reg <= EXC_NONE;
      tx_len_reg <= EXC_LEN;
      chk_reg <= 16'h0000;
    end
    else
    begin
      unique case (state_reg)
        ST_RX:
        begin
          if (end_ev && frame_good)
            state_reg <= ST_EVAL;
        end
        ST_EVAL:
        begin
          chk_reg <= 16'h0000;
          if (eval_exc != EXC_NONE)
          begin
            kind_reg <= RESP_EXC;
            exc_reg <= eval_exc;
            tx_len_reg <= EXC_LEN;
            state_reg <= ST_LOAD;
          end
          else if (fc == FC_WRITE_ONE)
          begin
            kind_reg <= RESP_WRITE;
            tx_len_reg <= ECHO_LEN;
            state_reg <= ST_LOAD;
          end
          else
          begin
            kind_reg <= RESP_READ;
            tx_len_reg <= EXC_LEN + {arg[6:0], 1'b0};
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          if (!rd_hit)
          begin
            kind_reg <= RESP_EXC;
            exc_reg <= EXC_ADDR;
            tx_len_reg <= EXC_LEN;
            state_reg <= ST_LOAD;
          end
          else if (chk_reg == arg - 16'h0001)
            state_reg <= ST_LOAD;
          else
            chk_reg <= chk_reg + 16'h0001;
        end
        ST_LOAD:
          state_reg <= ST_SEND;
        ST_SEND:
        begin
          if (tx_fire)
            state_reg <= (tx_idx_reg == tx_len_reg - 8'h01) ? ST_RX : ST_LOAD;
        end
      endcase
    end
  end

  // Reply byte for the current position
  always_comb
  begin
    if (tx_idx_reg == tx_len_reg - 8'h02)
      byte_next = tx_crc[7:0];
    else if (tx_idx_reg == tx_len_reg - 8'h01)
      byte_next = tx_crc[15:8];
    else if (tx_idx_reg == 8'h00)
      byte_next = buf_reg[0];
    else
    begin
      unique case (kind_reg)
        RESP_EXC:
          byte_next = (tx_idx_reg == 8'h01) ? (fc | EXC_FLAG) : exc_reg;
        RESP_WRITE:
          byte_next = buf_reg[tx_idx_reg[2:0]];
        RESP_READ:
        begin
          if (tx_idx_reg == 8'h01)
            byte_next = fc;
          else if (tx_idx_reg == 8'h02)
            byte_next = {arg[6:0], 1'b0};
          else
            byte_next = doff[0] ? rd_data[7:0] : rd_data[15:8];
        end
        default:
          byte_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tx_data_reg <= 8'h00;
    else if (state_reg == ST_LOAD)
      tx_data_reg <= byte_next;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tx_idx_reg <= 8'h00;
    else if (state_reg == ST_EVAL)
      tx_idx_reg <= 8'h00;
    else if (tx_fire)
      tx_idx_reg <= tx_idx_reg + 8'h01;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_fc_byte;
    (state_reg == ST_SEND) && (tx_idx_reg == 8'h01);
  endsequence
  sequence s_crc_lo;
    (state_reg == ST_SEND) && (tx_idx_reg == tx_len_reg - 8'h02) && tx_fire;
  endsequence
  sequence s_checked_eval;
    (state_reg == ST_EVAL) && pre_ok;
  endsequence

  a_norm_fc_echo: assert property (
    (s_fc_byte ##0 (kind_reg != RESP_EXC)) |-> o_tx_data == buf_reg[1])
    else $error("normal reply does not echo function code");
  a_reply_follows: assert property (
    (end_ev && frame_good && !i_busy) |-> ##[2:20] (state_reg == ST_SEND))
    else $error("clean query got no reply");
  a_exc_fc_flag: assert property (
    (s_fc_byte ##0 (kind_reg == RESP_EXC)) |-> o_tx_data == (buf_reg[1] | EXC_FLAG))
    else $error("exception function code lacks top bit");
  a_bad_frame_quiet: assert property (
    (end_ev && !frame_good) |=> (!o_tx_valid && (state_reg == ST_RX))[*3])
    else $error("reply sent for corrupted frame");
  a_exc_code_byte: assert property (
    ((state_reg == ST_SEND) && (kind_reg == RESP_EXC) && (tx_idx_reg == 8'h02)) |->
    o_tx_data == exc_reg && tx_len_reg == EXC_LEN)
    else $error("exception code byte wrong");
  a_unmapped_read: assert property (
    ((state_reg == ST_CHECK) && !rd_hit) |=>
    (state_reg == ST_LOAD) && (exc_reg == EXC_ADDR) ##1 (state_reg == ST_SEND))
    else $error("unmapped read not refused with address code");
  a_unmapped_write: assert property (
    (s_checked_eval ##0 ((fc == FC_WRITE_ONE) && !wr_hit)) |=> exc_reg == EXC_ADDR)
    else $error("unmapped write not refused with address code");
  a_bad_func: assert property (
    ((state_reg == ST_EVAL) && !i_busy && !i_fault && !i_nak && !fc_known) |=>
    (kind_reg == RESP_EXC) && (exc_reg == EXC_ILL_FUNC))
    else $error("unknown function not refused");
  a_range_refuse: assert property (
    (s_checked_eval ##0 ((fc == FC_WRITE_ONE) && wr_hit && !wr_ok)) |->
    !wr_en ##1 (exc_reg == EXC_VALUE))
    else $error("out of range write not refused");
  a_fault_code: assert property (
    ((state_reg == ST_EVAL) && !i_busy && i_fault) |=> exc_reg == EXC_FAIL)
    else $error("fault state not reported");
  a_busy_reject: assert property (
    ((state_reg == ST_EVAL) && i_busy) |-> !wr_en ##1
    ((state_reg == ST_LOAD) && (exc_reg == EXC_BUSY)))
    else $error("busy device did not reject query");
  a_nak_code: assert property (
    ((state_reg == ST_EVAL) && !i_busy && !i_fault && i_nak) |=> exc_reg == EXC_NAK)
    else $error("negative acknowledge not reported");
  a_file_overflow: assert property (
    (s_checked_eval ##0 ((fc == FC_READ_FILE) && (arg > RESP_WORDS))) |=>
    exc_reg == EXC_OVERFLOW)
    else $error("file read overflow not reported");
  a_status_reply: assert property (
    ((state_reg == ST_LOAD) && (kind_reg == RESP_READ) && (rd_addr == OFS_STATUS) &&
    (tx_idx_reg > 8'h02) && doff[0] && (tx_idx_reg < tx_len_reg - 8'h02)) |=>
    o_tx_data == {o_cfg.event_high, i_alarm_active})
    else $error("alarm status byte wrong in reply");
  a_crc_low_first: assert property (
    s_crc_lo |-> (o_tx_data == tx_crc[7:0]) ##2 (o_tx_data == tx_crc[15:8]))
    else $error("reply CRC order wrong");
endmodule : modbus_slave_exception_regs
`default_nettype wire

// ===== bench/modbus_master_model.sv
// Purpose: Serial master that frames queries and collects replies
// Assumes: Replies are taken at once; one query at a time
// Notes: Silence past the reply window leaves the reply queue empty
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
  // Clock
  input wire logic i_clk,
  // Reply bytes from the slave
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  // Query bytes to the slave
  output modbus_slave_pkg::rx_t o_rx
);
  import modbus_slave_pkg::*;
  logic [7:0] rsp[$];
  initial o_rx = '0;
  initial o_tx_ready = 1'b1;
  always @(posedge i_clk) if (i_tx_valid === 1'b1) rsp.push_back(i_tx_data);
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16
  // Bit 0 of bad spoils the CRC, bit 1 flags a parity error on the third byte
  task automatic send(input logic [7:0] ad, fc, input logic [15:0] a, v, input logic [1:0] bad);
    logic [7:0] q[$];
    logic [15:0] c;
    q = '{ad, fc, a[15:8], a[7:0], v[15:8], v[7:0]};
    c = crc16(q) ^ {15'h0000, bad[0]};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    rsp.delete();
    foreach (q[i])
    begin
      @(negedge i_clk) o_rx <= '{valid: 1'b1, data: q[i], err: bad[1] && (i == 2), frame_end: 1'b0};
      @(negedge i_clk) o_rx <= '0;
    end
    @(negedge i_clk) o_rx <= '{valid: 1'b0, data: 8'h00, err: 1'b0, frame_end: 1'b1};
    @(negedge i_clk) o_rx <= '0;
    repeat (60) @(negedge i_clk);
  endtask : send
endmodule : modbus_master_model
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the serial slave responder
// Assumes: Reply buffer shortened to two words
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import modbus_slave_pkg::*;
  logic i_clk, i_rst_n, busy, fault, nak, tx_valid, tx_ready;
  logic [7:0] tx_data;
  logic [3:0] act;
  rx_t rx;
  cfg_t cfg;
  int n_mismatch, cmp_count, cyc;
  modbus_slave_exception_regs #(.RESP_WORDS(16'h0002)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_rx(rx), .o_tx_data(tx_data), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
    .i_slave_addr(8'h11), .i_busy(busy), .i_fault(fault), .i_nak(nak),
    .i_alarm_active(act), .o_cfg(cfg));
  modbus_master_model m (.i_clk(i_clk), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .o_rx(rx));
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic chk(input string s, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic xq(input logic [7:0] fc, input logic [15:0] a, v, input logic [7:0] efc, eb);
    m.send(8'h11, fc, a, v, 2'b00);
    chk("function code", {8'h00, efc}, {8'h00, m.rsp[1]});
    chk("third byte", {8'h00, eb}, {8'h00, m.rsp[2]});
    chk("reply crc", 16'h0000, m.crc16(m.rsp));
  endtask : xq
  task automatic sc_reset();
    chk("reset hyst", 16'h0000, cfg.hyst_hi);
    chk("reset cfg", 16'h0000, {4'h0, cfg[11:0]});
  endtask : sc_reset
  task automatic sc_status();
    act = 4'h5;
    xq(FC_WRITE_ONE, OFS_A1S1_EV, 16'h0001, FC_WRITE_ONE, 8'h00);
    chk("event high", 16'h0001, {12'h000, cfg.event_high});
    xq(FC_READ_HOLD, OFS_STATUS, 16'h0001, FC_READ_HOLD, 8'h02);
    chk("status", 16'h0015, {m.rsp[3], m.rsp[4]});
  endtask : sc_status
  task automatic sc_regs();
    xq(FC_WRITE_ONE, OFS_LATCH, 16'h0001, FC_WRITE_ONE, 8'h00);
    xq(FC_WRITE_ONE, OFS_BLOCK, 16'h0003, FC_WRITE_ONE, 8'h00);
    xq(FC_WRITE_ONE, OFS_MAINS, 16'h0001, FC_WRITE_ONE, 8'h00);
    chk("cfg bits", 16'h0007, {13'h0000, cfg.alarm_latch, cfg.block_sel});
    chk("50 Hz", 16'h0001, {15'h0000, cfg.mains_50hz});
    xq(FC_WRITE_ONE, OFS_BLOCK, 16'h0004, 8'h86, EXC_VALUE);
    chk("block kept", 16'h0003, {14'h0000, cfg.block_sel});
    xq(FC_WRITE_ONE, OFS_HYST_HI, 16'h42C9, 8'h86, EXC_VALUE);
    xq(FC_WRITE_ONE, OFS_HYST_HI, 16'h42C8, FC_WRITE_ONE, 8'h00);
    chk("hyst", 16'h42C8, cfg.hyst_hi);
    xq(FC_WRITE_ONE, OFS_DIAG, 16'h0002, FC_WRITE_ONE, 8'h00);
    xq(FC_WRITE_ONE, OFS_LOWER_EN, 16'h0001, FC_WRITE_ONE, 8'h00);
    xq(FC_WRITE_ONE, OFS_TC_DIAG, 16'h0001, FC_WRITE_ONE, 8'h00);
    chk("aux cfg", 16'h000B,
        {12'h000, cfg.diag_route, cfg.lower_disp_off, cfg.tc_diag_off});
  endtask : sc_regs
  task automatic sc_exc();
    logic [7:0] ec[3];
    ec = '{EXC_BUSY, EXC_FAIL, EXC_NAK};
    xq(FC_WRITE_ONE, 16'h0000, 16'h0000, 8'h86, EXC_ADDR);
    xq(8'h05, OFS_LATCH, 16'h0000, 8'h85, EXC_ILL_FUNC);
    xq(FC_READ_FILE, OFS_STATUS, 16'h0003, 8'h94, EXC_OVERFLOW);
    xq(FC_READ_INPUT, OFS_BLOCK, 16'h0002, 8'h84, EXC_ADDR);
    xq(FC_READ_HOLD, OFS_LATCH, 16'h0000, 8'h83, EXC_VALUE);
    for (int i = 0; i < 3; i++)
    begin
      {nak, fault, busy} = 3'b001 << i;
      xq(FC_READ_HOLD, OFS_LATCH, 16'h0001, 8'h83, ec[i]);
    end
    {nak, fault, busy} = 3'b000;
    m.send(8'h11, FC_READ_HOLD, OFS_LATCH, 16'h0001, 2'b01);
    chk("silent", 16'h0000, 16'(m.rsp.size()));
    m.send(8'h11, FC_READ_HOLD, OFS_LATCH, 16'h0001, 2'b10);
    chk("silent parity", 16'h0000, 16'(m.rsp.size()));
  endtask : sc_exc
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial
  begin
    {i_rst_n, busy, fault, nak, act} = '0;
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    sc_reset();
    sc_status();
    sc_regs();
    sc_exc();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
